// [bench/iosi_unit.sv]
`timescale 1ns/100ps
`default_nettype none
module iosi_unit #(
  parameter logic [5:0] UNIT_ID = 6'h01,
  parameter logic [5:0] STAT_FN = 6'h3F,
  parameter logic [5:0] RESP_FN = 6'h3E,
  parameter int DELAY = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire iosi_pkg::iosi_select_type code,
  input wire logic strobe,
  input wire logic raise,
  output logic ack,
  output logic req
);
  logic [7:0] cnt_q;
  wire logic hit = strobe && code.unit == UNIT_ID;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 8'h00;
      ack <= 1'b0;
      req <= 1'b0;
    end else begin
      cnt_q <= (hit && !ack) ? cnt_q + 8'h01 : 8'h00;
      if (hit && cnt_q == 8'(DELAY)) begin
        ack <= 1'b1;
        if (code.func == STAT_FN) req <= 1'b0;
        if (code.func == RESP_FN) req <= 1'b0;
      end else if (!strobe) begin
        ack <= 1'b0;
      end
      if (raise) req <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "iosi_regs.svh"
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [1:0] raise = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, fready, irq, ack_a, ack_b;
  logic [1:0] bresp, rresp, r;
  wire [1:0] ext_irq;
  logic [31:0] rdata, d;
  iosi_pkg::iosi_select_type code;
  int fails = 0;
  int n_checks = 0;
  int i;
  localparam logic [5:0] ID_A = 6'h05;
  localparam logic [5:0] ID_B = 6'h22;
  localparam logic [5:0] STAT = 6'h3F;
  localparam logic [5:0] RESP = 6'h3E;
  always #2 aclk = ~aclk;
  iosi_top u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_function_code(code), .function_ready(fready),
    .output_resume(ack_a | ack_b), .ext_irq(ext_irq), .irq(irq));
  // distinct designators per unit
  iosi_unit #(.UNIT_ID(ID_A), .STAT_FN(STAT), .RESP_FN(RESP)) u_unit_a (
    .aclk(aclk), .aresetn(aresetn), .code(code), .strobe(fready),
    .raise(raise[0]), .ack(ack_a), .req(ext_irq[0]));
  iosi_unit #(.UNIT_ID(ID_B), .STAT_FN(STAT), .RESP_FN(RESP)) u_unit_b (
    .aclk(aclk), .aresetn(aresetn), .code(code), .strobe(fready),
    .raise(raise[1]), .ack(ack_b), .req(ext_irq[1]));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo();
    fails++;
    complete_run();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge aclk);
    awaddr <= {24'h000000, a};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (k == 50) tmo();
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr <= {24'h000000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (k == 50) tmo();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, string m);
    rd(a);
    chk(d, e, m);
    chk({30'h0, r}, {30'h0, `IOSI_RESP_OKAY}, "read response");
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 40; k++) begin
      rd(`IOSI_OFS_STATE);
      if (d[`IOSI_STA_BUSY] === 1'b0) break;
    end
    if (k == 40) tmo();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`IOSI_OFS_MASK, 32'h0, "mask reset");
    rdc(`IOSI_OFS_CONTROL, 32'h0, "lockout reset");
    rdc(`IOSI_OFS_STATUS, 32'h0, "status reset");
    // selection, then a refused write while busy
    wr(`IOSI_OFS_SELECT, {20'h0, ID_A, 6'h11});
    for (i = 0; i < 20 && fready !== 1'b1; i++) @(posedge aclk);
    if (i == 20) tmo();
    chk({20'h0, code}, {20'h0, ID_A, 6'h11}, "select code");
    wr(`IOSI_OFS_SELECT, {20'h0, ID_B, 6'h01});
    for (i = 0; i < 40 && ack_a !== 1'b1; i++) begin
      chk({31'h0, fready}, 32'h1, "strobe early drop");
      chk({31'h0, ack_b}, 32'h0, "foreign unit acknowledged");
      @(posedge aclk);
    end
    if (i == 40) tmo();
    wait_idle();
    chk({20'h0, code}, {20'h0, ID_A, 6'h11}, "code kept");
    rdc(`IOSI_OFS_STATUS, 32'h3, "internal levels");
    wr(`IOSI_OFS_STATUS, 32'h3);
    rdc(`IOSI_OFS_STATUS, 32'h0, "status clear");
    wr(8'h20, 32'h1);
    chk({30'h0, r}, {30'h0, `IOSI_RESP_SLVERR}, "unmapped write");
    rd(8'h20);
    chk({30'h0, r}, {30'h0, `IOSI_RESP_SLVERR}, "unmapped read");
    // external requests, mask and lockout
    raise <= 2'h3;
    @(posedge aclk);
    raise <= 2'h0;
    repeat (5) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "masked irq");
    rdc(`IOSI_OFS_STATUS, 32'hC, "external levels");
    wr(`IOSI_OFS_MASK, 32'hC);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1, "irq on");
    wr(`IOSI_OFS_CONTROL, 32'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "lockout");
    wr(`IOSI_OFS_CONTROL, 32'h0);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1, "lockout off");
    // status request to one suspect, function response to the other
    wr(`IOSI_OFS_SELECT, {20'h0, ID_A, STAT});
    wait_idle();
    chk({30'h0, ext_irq}, 32'h2, "status request drop");
    wr(`IOSI_OFS_SELECT, {20'h0, ID_B, RESP});
    wait_idle();
    chk({30'h0, ext_irq}, 32'h0, "function response drop");
    wr(`IOSI_OFS_STATUS, 32'hF);
    repeat (4) @(posedge aclk);
    rdc(`IOSI_OFS_STATUS, 32'h0, "status clear");
    chk({31'h0, irq}, 32'h0, "irq off");
    complete_run();
  end
endmodule
`default_nettype wire

// [verilog/iosi_pkg.sv]
package iosi_pkg;

  // select code as placed on the output lines
  typedef struct packed {
    logic [5:0] unit;
    logic [5:0] func;
  } iosi_select_type;

  // selection handshake
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_OFFER,
    ST_RELEASE
  } iosi_state_type;

endpackage

// [verilog/iosi_regs.svh]
`ifndef IOSI_REGS_SVH
`define IOSI_REGS_SVH

// register byte offsets, compared against address bits [7:0]
`define IOSI_OFS_SELECT 8'h00
`define IOSI_OFS_STATUS 8'h04
`define IOSI_OFS_MASK 8'h08
`define IOSI_OFS_CONTROL 8'h0C
`define IOSI_OFS_STATE 8'h10
`define IOSI_OFS_MSB 7

// status and mask bit positions, one per interrupt level
`define IOSI_LVL_10 0
`define IOSI_LVL_20 1
`define IOSI_LVL_30 2
`define IOSI_LVL_40 3
`define IOSI_LVL_N 4

// control and state bit positions
`define IOSI_CTL_LOCKOUT 0
`define IOSI_STA_BUSY 0
`define IOSI_STA_RESUME 1
`define IOSI_STA_EXT_LO 2
`define IOSI_STA_EXT_HI 3

// field widths and reset values
`define IOSI_CODE_W 12
`define IOSI_BYTE_W 8
`define IOSI_CODE_RST 12'h000
`define IOSI_MASK_RST 4'h0
`define IOSI_STATUS_RST 4'h0
`define IOSI_LOCKOUT_RST 1'b0

// axi responses
`define IOSI_RESP_OKAY 2'b00
`define IOSI_RESP_SLVERR 2'b10

`endif

// [verilog/iosi_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module iosi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // two flops, the first read only by the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// [verilog/iosi_top.sv]
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "iosi_regs.svh"

module iosi_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output iosi_pkg::iosi_select_type external_function_code,
  output logic function_ready,
  input wire logic output_resume,
  input wire logic [1:0] ext_irq,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] pins_s;
  logic ack_s;
  logic [1:0] ext_s;

  iosi_sync #(
    .WIDTH(3)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({ext_irq, output_resume}),
    .sync_out(pins_s)
  );

  assign ack_s = pins_s[0];
  assign ext_s = pins_s[2:1];

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  logic aw_full_q, w_full_q;
  logic [`IOSI_OFS_MSB:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_take, w_take, wr_fire, aw_full_d, w_full_d, bvalid_d;
  logic wr_hit_sel, wr_hit_sts, wr_hit_msk, wr_hit_ctl, wr_mapped;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign aw_full_d = (aw_full_q | aw_take) & ~wr_fire;
  assign w_full_d = (w_full_q | w_take) & ~wr_fire;
  assign bvalid_d = (s_axi_bvalid & ~s_axi_bready) | wr_fire;

  assign wr_hit_sel = aw_addr_q == `IOSI_OFS_SELECT;
  assign wr_hit_sts = aw_addr_q == `IOSI_OFS_STATUS;
  assign wr_hit_msk = aw_addr_q == `IOSI_OFS_MASK;
  assign wr_hit_ctl = aw_addr_q == `IOSI_OFS_CONTROL;
  assign wr_mapped = wr_hit_sel | wr_hit_sts | wr_hit_msk | wr_hit_ctl
    | (aw_addr_q == `IOSI_OFS_STATE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IOSI_RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      s_axi_awready <= ~aw_full_d;
      s_axi_wready <= ~w_full_d;
      s_axi_bvalid <= bvalid_d;
      if (wr_fire) begin
        s_axi_bresp <= wr_mapped ? `IOSI_RESP_OKAY : `IOSI_RESP_SLVERR;
      end
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr[`IOSI_OFS_MSB:0];
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and select handshake

  iosi_pkg::iosi_state_type state_q, state_d;
  logic [`IOSI_CODE_W-1:0] code_d;
  logic [`IOSI_LVL_N-1:0] status_q, mask_q, ev, clr, status_d;
  logic lockout_q, sel_wr, launch, refuse, accepted;

  assign sel_wr = wr_fire & wr_hit_sel & (w_strb_q[0] | w_strb_q[1]);
  // status requests are select codes too, issued the same way
  assign launch = sel_wr & (state_q == iosi_pkg::ST_IDLE);
  assign refuse = sel_wr & (state_q != iosi_pkg::ST_IDLE);
  assign accepted = (state_q == iosi_pkg::ST_OFFER) & ack_s;
  assign code_d[`IOSI_CODE_W-1:`IOSI_BYTE_W] = w_strb_q[1] ?
    w_data_q[`IOSI_CODE_W-1:`IOSI_BYTE_W] :
    external_function_code[`IOSI_CODE_W-1:`IOSI_BYTE_W];
  assign code_d[`IOSI_BYTE_W-1:0] = w_strb_q[0] ?
    w_data_q[`IOSI_BYTE_W-1:0] : external_function_code[`IOSI_BYTE_W-1:0];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      iosi_pkg::ST_IDLE: begin
        if (launch) begin
          state_d = iosi_pkg::ST_OFFER;
        end
      end
      iosi_pkg::ST_OFFER: begin
        if (ack_s) begin
          state_d = iosi_pkg::ST_RELEASE;
        end
      end
      iosi_pkg::ST_RELEASE: begin
        if (!ack_s) begin
          state_d = iosi_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // sticky events; a new event beats a same-cycle clear
  assign ev[`IOSI_LVL_10] = accepted;
  assign ev[`IOSI_LVL_20] = refuse;
  assign ev[`IOSI_LVL_30] = ext_s[0];
  assign ev[`IOSI_LVL_40] = ext_s[1];
  assign clr = (wr_fire & wr_hit_sts & w_strb_q[0]) ?
    w_data_q[`IOSI_LVL_N-1:0] : `IOSI_STATUS_RST;
  assign status_d = (status_q & ~clr) | ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= iosi_pkg::ST_IDLE;
      function_ready <= 1'b0;
      external_function_code <= `IOSI_CODE_RST;
      status_q <= `IOSI_STATUS_RST;
      mask_q <= `IOSI_MASK_RST;
      lockout_q <= `IOSI_LOCKOUT_RST;
      irq <= 1'b0;
    end else begin
      state_q <= state_d;
      function_ready <= state_d == iosi_pkg::ST_OFFER;
      if (launch) begin
        external_function_code <= code_d;
      end
      status_q <= status_d;
      if (wr_fire & wr_hit_msk & w_strb_q[0]) begin
        mask_q <= w_data_q[`IOSI_LVL_N-1:0];
      end
      if (wr_fire & wr_hit_ctl & w_strb_q[0]) begin
        lockout_q <= w_data_q[`IOSI_CTL_LOCKOUT];
      end
      irq <= (|(status_q & mask_q)) & ~lockout_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  logic ar_take, rvalid_d, rd_mapped;
  logic [`IOSI_OFS_MSB:0] rd_addr;
  logic [31:0] rd_word, state_word;

  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rvalid_d = (s_axi_rvalid & ~s_axi_rready) | ar_take;
  assign rd_addr = s_axi_araddr[`IOSI_OFS_MSB:0];

  always_comb begin
    state_word = '0;
    state_word[`IOSI_STA_BUSY] = state_q != iosi_pkg::ST_IDLE;
    state_word[`IOSI_STA_RESUME] = ack_s;
    state_word[`IOSI_STA_EXT_HI:`IOSI_STA_EXT_LO] = ext_s;
  end

  always_comb begin
    rd_word = '0;
    rd_mapped = 1'b1;
    unique case (rd_addr)
      `IOSI_OFS_SELECT: rd_word[`IOSI_CODE_W-1:0] = external_function_code;
      `IOSI_OFS_STATUS: rd_word[`IOSI_LVL_N-1:0] = status_q;
      `IOSI_OFS_MASK: rd_word[`IOSI_LVL_N-1:0] = mask_q;
      `IOSI_OFS_CONTROL: rd_word[`IOSI_CTL_LOCKOUT] = lockout_q;
      `IOSI_OFS_STATE: rd_word = state_word;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `IOSI_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? `IOSI_RESP_OKAY : `IOSI_RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  strobe_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    function_ready && !ack_s && state_q == iosi_pkg::ST_OFFER
      |=> function_ready)
    else $error("strobe dropped before acknowledge");

  strobe_drop_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    function_ready && ack_s |=> !function_ready ##1 !function_ready)
    else $error("strobe not dropped after acknowledge");

  code_stable_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    function_ready ##1 function_ready |-> $stable(external_function_code))
    else $error("select code changed under strobe");

  launch_start_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    launch |=> function_ready && external_function_code == $past(code_d))
    else $error("select write did not drive code and strobe");

  lockout_gate_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    lockout_q |=> !irq)
    else $error("interrupt raised under lockout");

  irq_raise_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !lockout_q && (|(status_q & mask_q)) |=> irq)
    else $error("unmasked level did not interrupt");

  ext_latch_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ext_irq[1] ##2 1'b1 |=> status_q[`IOSI_LVL_40])
    else $error("external request not latched");

  refuse_flag_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    refuse |=> status_q[`IOSI_LVL_20] && $stable(external_function_code))
    else $error("busy select write not flagged");

endmodule

`default_nettype wire
